// File: pkg/eapps_pkg.sv
package eapps_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] EAPPS_OFS_BUS_CTRL   = 4'h0;
    localparam logic [3:0] EAPPS_OFS_A_FUNC     = 4'h1;
    localparam logic [3:0] EAPPS_OFS_A_DIR      = 4'h2;
    localparam logic [3:0] EAPPS_OFS_A_DATA     = 4'h3;
    localparam logic [3:0] EAPPS_OFS_A_PULLUP   = 4'h4;
    localparam logic [3:0] EAPPS_OFS_B_PERIPH   = 4'h5;
    localparam logic [3:0] EAPPS_OFS_B_DIR      = 4'h6;
    localparam logic [3:0] EAPPS_OFS_B_DATA     = 4'h7;
    localparam logic [3:0] EAPPS_OFS_B_PULLUP   = 4'h8;
    localparam logic [3:0] EAPPS_OFS_A_PINS     = 4'h9;
    localparam logic [3:0] EAPPS_OFS_B_PINS     = 4'hA;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int         EAPPS_DRV_BIT        = 0;
    localparam logic       EAPPS_RST_DRV        = 1'h0;
    localparam logic [7:0] EAPPS_RST_A_FUNC     = 8'h00;
    localparam logic [7:0] EAPPS_RST_A_PULLUP   = 8'hFF;
    localparam logic [3:0] EAPPS_RST_B_PULLUP   = 4'hF;
    localparam logic [7:0] EAPPS_RST_A_DIR      = 8'h00;
    localparam logic [3:0] EAPPS_RST_B_DIR      = 4'h0;
    localparam logic [7:0] EAPPS_RST_A_DATA     = 8'h00;
    localparam logic [3:0] EAPPS_RST_B_DATA     = 4'h0;
    localparam logic [3:0] EAPPS_RST_B_PER      = 4'h0;

endpackage : eapps_pkg

// File: core/eapps_pin_share.sv
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

// How it works
// RULE_01 - address lines 8..15 are driven out on the port A pins for external accesses.
// RULE_02 - with bus drive select clear, address pins float while the external bus is idle.
// RULE_03 - each port A pin in gpio use has its own direction bit.
// RULE_04 - after reset port A pins take the address function.
// RULE_05 - every shared pin has a pull-up that stays on until its enable bit is cleared.
// RULE_06 - pull-up enable bit n controls port pin n.
// RULE_07 - each port B pin in gpio use has its own direction bit.
// RULE_08 - port B pins in address use carry address lines 16..19.
// RULE_09 - port B function after reset follows the memory mode strap and flash security.
// RULE_10 - port B peripheral enable bits turn gpio off per pin for address use.
// RULE_11 - all shared pins float during reset.
module eapps_pin_share
    import eapps_pkg::*;
#(
    parameter int A_W = 8,
    parameter int B_W = 4
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [3:0]       reg_addr,
    input  wire logic [15:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [15:0]      reg_rdata,
    input  wire logic [19:8]      ext_addr,
    input  wire logic             ext_bus_active,
    input  wire logic             ext_mem_mode_strap,
    input  wire logic             flash_secure,
    input  wire logic [A_W-1:0]   pa_in,
    output logic      [A_W-1:0]   pa_out,
    output logic      [A_W-1:0]   pa_oe_n,
    output logic      [A_W-1:0]   pa_pullup,
    input  wire logic [B_W-1:0]   pb_in,
    output logic      [B_W-1:0]   pb_out,
    output logic      [B_W-1:0]   pb_oe_n,
    output logic      [B_W-1:0]   pb_pullup
);

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic             drv_r,     drv_nxt;
    logic [A_W-1:0]   a_func_r,  a_func_nxt;
    logic [A_W-1:0]   a_dir_r,   a_dir_nxt;
    logic [A_W-1:0]   a_dat_r,   a_dat_nxt;
    logic [A_W-1:0]   a_pu_r,    a_pu_nxt;
    logic [B_W-1:0]   b_per_r,   b_per_nxt;
    logic [B_W-1:0]   b_dir_r,   b_dir_nxt;
    logic [B_W-1:0]   b_dat_r,   b_dat_nxt;
    logic [B_W-1:0]   b_pu_r,    b_pu_nxt;
    logic             strap_done_r, strap_done_nxt;
    logic [15:0]      rdata_nxt;
    logic [A_W-1:0]   pa_s1_r, pa_s2_r, pa_s3_r, pa_q_r, pa_q_nxt;
    logic [B_W-1:0]   pb_s1_r, pb_s2_r, pb_s3_r, pb_q_r, pb_q_nxt;
    logic [A_W-1:0]   pa_out_nxt, pa_oe_nxt;
    logic [B_W-1:0]   pb_out_nxt, pb_oe_nxt;
    logic             addr_drive;

    // ------------------------------------------------------------
    // register write and strap capture
    // ------------------------------------------------------------
    always_comb begin
        drv_nxt        = drv_r;
        a_func_nxt     = a_func_r;
        a_dir_nxt      = a_dir_r;
        a_dat_nxt      = a_dat_r;
        a_pu_nxt       = a_pu_r;
        b_per_nxt      = b_per_r;
        b_dir_nxt      = b_dir_r;
        b_dat_nxt      = b_dat_r;
        b_pu_nxt       = b_pu_r;
        strap_done_nxt = 1'h1;
        // strap caught on first cycle after reset
        if (!strap_done_r) begin
            b_per_nxt = (ext_mem_mode_strap && !flash_secure) ? {B_W{1'b1}} : {B_W{1'b0}}; // RULE_09
        end
        if (reg_wr) begin
            unique case (reg_addr)
                EAPPS_OFS_BUS_CTRL: drv_nxt    = reg_wdata[EAPPS_DRV_BIT];     // RULE_02
                EAPPS_OFS_A_FUNC:   a_func_nxt = reg_wdata[A_W-1:0];
                EAPPS_OFS_A_DIR:    a_dir_nxt  = reg_wdata[A_W-1:0];           // RULE_03
                EAPPS_OFS_A_DATA:   a_dat_nxt  = reg_wdata[A_W-1:0];
                EAPPS_OFS_A_PULLUP: a_pu_nxt   = reg_wdata[A_W-1:0];           // RULE_06
                EAPPS_OFS_B_PERIPH: b_per_nxt  = reg_wdata[B_W-1:0];           // RULE_10
                EAPPS_OFS_B_DIR:    b_dir_nxt  = reg_wdata[B_W-1:0];           // RULE_07
                EAPPS_OFS_B_DATA:   b_dat_nxt  = reg_wdata[B_W-1:0];
                EAPPS_OFS_B_PULLUP: b_pu_nxt   = reg_wdata[B_W-1:0];           // RULE_06
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // control register state
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            drv_r        <= EAPPS_RST_DRV;
            a_func_r     <= EAPPS_RST_A_FUNC;                                  // RULE_04
            a_dir_r      <= EAPPS_RST_A_DIR;
            a_dat_r      <= EAPPS_RST_A_DATA;
            a_pu_r       <= EAPPS_RST_A_PULLUP;                                // RULE_05
            b_per_r      <= EAPPS_RST_B_PER;
            b_dir_r      <= EAPPS_RST_B_DIR;
            b_dat_r      <= EAPPS_RST_B_DATA;
            b_pu_r       <= EAPPS_RST_B_PULLUP;                                // RULE_05
            strap_done_r <= 1'h0;
        end else begin
            drv_r        <= drv_nxt;
            a_func_r     <= a_func_nxt;
            a_dir_r      <= a_dir_nxt;
            a_dat_r      <= a_dat_nxt;
            a_pu_r       <= a_pu_nxt;
            b_per_r      <= b_per_nxt;
            b_dir_r      <= b_dir_nxt;
            b_dat_r      <= b_dat_nxt;
            b_pu_r       <= b_pu_nxt;
            strap_done_r <= strap_done_nxt;
        end
    end

    // ------------------------------------------------------------
    // pin input synchronisers
    // ------------------------------------------------------------
    always_comb begin
        pa_q_nxt = pa_q_r;
        pb_q_nxt = pb_q_r;
        if (pa_s2_r == pa_s3_r) begin
            pa_q_nxt = pa_s3_r;
        end
        if (pb_s2_r == pb_s3_r) begin
            pb_q_nxt = pb_s3_r;
        end
    end

    always_ff @(posedge clk) begin
        pa_s1_r <= pa_in;
        pa_s2_r <= pa_s1_r;
        pa_s3_r <= pa_s2_r;
        pb_s1_r <= pb_in;
        pb_s2_r <= pb_s1_r;
        pb_s3_r <= pb_s2_r;
        if (reset) begin
            pa_q_r <= '0;
            pb_q_r <= '0;
        end else begin
            pa_q_r <= pa_q_nxt;
            pb_q_r <= pb_q_nxt;
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    assign addr_drive = ext_bus_active || drv_r;                               // RULE_02

    always_comb begin
        for (int i = 0; i < A_W; i++) begin
            if (!a_func_r[i]) begin
                pa_out_nxt[i] = ext_addr[8+i];                                 // RULE_01
                pa_oe_nxt[i]  = !addr_drive;
            end else begin
                pa_out_nxt[i] = a_dat_r[i];
                pa_oe_nxt[i]  = !a_dir_r[i];                                   // RULE_03
            end
        end
        for (int j = 0; j < B_W; j++) begin
            if (b_per_r[j]) begin
                pb_out_nxt[j] = ext_addr[16+j];                                // RULE_08
                pb_oe_nxt[j]  = !addr_drive;
            end else begin
                pb_out_nxt[j] = b_dat_r[j];
                pb_oe_nxt[j]  = !b_dir_r[j];                                   // RULE_07
            end
        end
    end

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    always_comb begin
        rdata_nxt = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                EAPPS_OFS_BUS_CTRL: rdata_nxt[EAPPS_DRV_BIT] = drv_r;
                EAPPS_OFS_A_FUNC:   rdata_nxt[A_W-1:0] = a_func_r;
                EAPPS_OFS_A_DIR:    rdata_nxt[A_W-1:0] = a_dir_r;
                EAPPS_OFS_A_DATA:   rdata_nxt[A_W-1:0] = a_dat_r;
                EAPPS_OFS_A_PULLUP: rdata_nxt[A_W-1:0] = a_pu_r;
                EAPPS_OFS_B_PERIPH: rdata_nxt[B_W-1:0] = b_per_r;
                EAPPS_OFS_B_DIR:    rdata_nxt[B_W-1:0] = b_dir_r;
                EAPPS_OFS_B_DATA:   rdata_nxt[B_W-1:0] = b_dat_r;
                EAPPS_OFS_B_PULLUP: rdata_nxt[B_W-1:0] = b_pu_r;
                EAPPS_OFS_A_PINS:   rdata_nxt[A_W-1:0] = pa_q_r;
                EAPPS_OFS_B_PINS:   rdata_nxt[B_W-1:0] = pb_q_r;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= '0;
            pa_out    <= '0;
            pa_oe_n   <= '1;                                                   // RULE_11
            pa_pullup <= EAPPS_RST_A_PULLUP;
            pb_out    <= '0;
            pb_oe_n   <= '1;                                                   // RULE_11
            pb_pullup <= EAPPS_RST_B_PULLUP;
        end else begin
            reg_rdata <= rdata_nxt;
            pa_out    <= pa_out_nxt;
            pa_oe_n   <= pa_oe_nxt;
            pa_pullup <= a_pu_r;                                               // RULE_05
            pb_out    <= pb_out_nxt;
            pb_oe_n   <= pb_oe_nxt;
            pb_pullup <= b_pu_r;                                               // RULE_05
        end
    end

endmodule : eapps_pin_share

// File: tb/eapps_pin_share_properties.sv
`timescale 1ns/1ps
module eapps_pin_share_properties
    import eapps_pkg::*;
#(
    parameter int A_W = 8,
    parameter int B_W = 4
) (
    input wire logic             clk,
    input wire logic             reset,
    input wire logic [3:0]       reg_addr,
    input wire logic             reg_wr,
    input wire logic             reg_rd,
    input wire logic [15:0]      reg_rdata,
    input wire logic [19:8]      ext_addr,
    input wire logic             ext_bus_active,
    input wire logic [A_W-1:0]   pa_out,
    input wire logic [A_W-1:0]   pa_oe_n,
    input wire logic [A_W-1:0]   pa_pullup,
    input wire logic [B_W-1:0]   pb_out,
    input wire logic [B_W-1:0]   pb_oe_n,
    input wire logic [B_W-1:0]   pb_pullup
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // port A setup touched since reset
    logic cfg_r;
    logic cfg_nxt;
    always_comb begin
        cfg_nxt = (cfg_r | (reg_wr & (reg_addr <= EAPPS_OFS_A_DIR))) & ~reset;
    end
    always_ff @(posedge clk) begin
        cfg_r <= cfg_nxt;
    end
    a_reset_float: assert property ($past(reset) |->
        &{pa_oe_n, pb_oe_n, pa_pullup, pb_pullup} && pa_out == '0 && pb_out == '0)
        else $error("pins not floating after reset");
    a_addr_drive: assert property (
        !cfg_r && !$past(reset) |-> pa_out == $past(ext_addr[15:8]))
        else $error("port A address value wrong");
    a_idle_float: assert property (
        !cfg_r && !$past(reset) && !$past(ext_bus_active) |-> &pa_oe_n)
        else $error("port A driven while bus idle");
    a_bus_drive: assert property (
        !cfg_r && !$past(reset) && $past(ext_bus_active) |-> pa_oe_n == '0)
        else $error("port A not driven during bus cycle");
    a_pullup_a: assert property (
        $past(reg_rd && !reset && reg_addr == EAPPS_OFS_A_PULLUP) |-> reg_rdata == 16'(pa_pullup))
        else $error("port A pull-up pins differ from register");
    a_pullup_b: assert property (
        $past(reg_rd && !reset && reg_addr == EAPPS_OFS_B_PULLUP) |-> reg_rdata == 16'(pb_pullup))
        else $error("port B pull-up pins differ from register");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside read cycle");
    a_unmapped_zero: assert property (
        $past(reg_rd) && $past(reg_addr) > EAPPS_OFS_B_PINS |-> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
endmodule : eapps_pin_share_properties
bind eapps_pin_share eapps_pin_share_properties #(.A_W(A_W), .B_W(B_W)) u_props (.*);

// File: tb/eapps_pin_world.sv
`timescale 1ns/1ps
module eapps_pin_world #(
    parameter int W = 8
) (
    input  wire logic           clk,
    input  wire logic [W-1:0]   drv,
    input  wire logic [W-1:0]   oe_n,
    input  wire logic [W-1:0]   pu_en,
    output logic      [W-1:0]   pin
);
    // undriven, unpulled lines wander every cycle
    logic [W-1:0] churn = '0;
    always @(posedge clk) churn <= ~churn;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pin[i] = !oe_n[i] ? drv[i] : (pu_en[i] ? 1'b1 : churn[i]);
        end
    end
endmodule : eapps_pin_world

// File: tb/eapps_pin_share_test.sv
`timescale 1ns/1ps
module eapps_pin_share_test
    import eapps_pkg::*;
;
    logic        clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, ext_bus_active = 0;
    logic        ext_mem_mode_strap = 1, flash_secure = 0;
    logic [3:0]  reg_addr = '0, pb_in, pb_out, pb_oe_n, pb_pullup;
    logic [15:0] reg_wdata = '0, reg_rdata;
    logic [19:8] ext_addr = '0, last_addr = '0;
    logic [7:0]  pa_in, pa_out, pa_oe_n, pa_pullup, d, v;
    integer      seed = 69599;
    int          err_count = 0, n_tests = 0;
    eapps_pin_share DUT (.*);
    eapps_pin_world #(.W(8)) u_pa (.clk(clk), .drv(pa_out), .oe_n(pa_oe_n),
        .pu_en(pa_pullup), .pin(pa_in));
    eapps_pin_world #(.W(4)) u_pb (.clk(clk), .drv(pb_out), .oe_n(pb_oe_n),
        .pu_en(pb_pullup), .pin(pb_in));
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        ext_addr <= 12'($random(seed));
        last_addr <= ext_addr;
    end
    function automatic logic [7:0] pin_exp(input logic [7:0] dir, input logic [7:0] dat);
        return (dat & dir) | ~dir;
    endfunction : pin_exp
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] w);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= w;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd
    task automatic bus(input logic act);
        @(posedge clk);
        ext_bus_active <= act;
        repeat (2) @(posedge clk);
        #1;
    endtask : bus
    task automatic close_out;
        $display("checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    initial begin
        #30000;
        err_count++;
        close_out();
    end
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(EAPPS_OFS_A_FUNC, 16'h0000);
        rd(EAPPS_OFS_B_PERIPH, 16'h000F);
        rd(EAPPS_OFS_A_PULLUP, 16'h00FF);
        rd(EAPPS_OFS_B_PULLUP, 16'h000F);
        rd(4'hF, 16'h0000);
        bus(1'b1);
        chk(16'({pb_out, pa_out}), 16'(last_addr));
        chk(16'({pb_oe_n, pa_oe_n}), 16'h0000);
        bus(1'b0);
        chk(16'({pb_oe_n, pa_oe_n}), 16'h0FFF);
        wr(EAPPS_OFS_BUS_CTRL, 16'h0001);
        bus(1'b0);
        chk(16'({pb_oe_n, pa_oe_n}), 16'h0000);
        wr(EAPPS_OFS_A_FUNC, 16'h00FF);
        for (int i = 0; i < 5; i++) begin
            d = (i == 0) ? 8'hFF : 8'($random(seed));
            v = 8'($random(seed));
            wr(EAPPS_OFS_A_DIR, {8'h00, d});
            wr(EAPPS_OFS_A_DATA, {8'h00, v});
            repeat (6) @(posedge clk);
            #1 chk(16'(pa_oe_n), {8'h00, ~d});
            rd(EAPPS_OFS_A_PINS, 16'(pin_exp(d, v)));
        end
        wr(EAPPS_OFS_A_PULLUP, 16'h00FE);
        bus(1'b0);
        chk(16'(pa_pullup), 16'h00FE);
        wr(EAPPS_OFS_B_PERIPH, 16'h0005);
        bus(1'b0);
        chk(16'(pb_oe_n), 16'h000A);
        wr(EAPPS_OFS_B_DIR, 16'h000F);
        wr(EAPPS_OFS_B_DATA, 16'h0002);
        bus(1'b0);
        chk(16'(pb_oe_n), 16'h0000);
        chk(16'(pb_out & 4'hA), 16'h0002);
        wr(EAPPS_OFS_B_PULLUP, 16'h0003);
        bus(1'b0);
        chk(16'(pb_pullup), 16'h0003);
        @(posedge clk);
        reset <= 1'b1;
        flash_secure <= 1'b1;
        bus(1'b1);
        chk(16'({pb_oe_n, pa_oe_n}), 16'h0FFF);
        reset <= 1'b0;
        rd(EAPPS_OFS_A_PULLUP, 16'h00FF);
        rd(EAPPS_OFS_B_PERIPH, 16'h0000);
        rd(EAPPS_OFS_B_PULLUP, 16'h000F);
        close_out();
    end
endmodule : eapps_pin_share_test
